/* verilog/rcp_pkg.sv */
`default_nettype none
package rcp_pkg;
	// Clock and timing
	localparam int CLK_NS = 10;
	localparam int PWR_UP_NS = 1000;
	localparam int SETUP_FORMATS = 16;
	localparam int WORD_CHARS = 10;
	// Characters seen on the command link
	localparam logic [7:0] CH_DOT = 8'h2E;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_STAR = 8'h2A;
	localparam logic [7:0] CH_DASH = 8'h2D;
	localparam logic [7:0] CH_COLON = 8'h3A;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_B = 8'h42;
	localparam logic [7:0] CH_E = 8'h45;
	localparam logic [7:0] CH_F = 8'h46;
	localparam logic [7:0] CH_S = 8'h53;
	localparam logic [7:0] CH_T = 8'h54;
	// Error codes
	localparam logic [6:0] ERR_CMD = 7'h00;
	localparam logic [6:0] ERR_PARAM = 7'h01;
	localparam logic [6:0] ERR_MODE = 7'h02;
	typedef enum logic [4:0] {CMD_UNKNOWN, CMD_BIT, CMD_CRITICAL, CMD_DECLASSIFY, CMD_DUB, CMD_ERASE,
		CMD_EVENT, CMD_FIND, CMD_PLAY, CMD_RECORD, CMD_REPLAY, CMD_RESET, CMD_SETUP, CMD_SHUTTLE,
		CMD_STATUS, CMD_STOP} rcp_cmd_t;
	typedef enum logic [3:0] {ST_POWER_ON, ST_BIT, ST_IDLE, ST_FAIL, ST_ERASE, ST_STARTING,
		ST_RECORD, ST_PLAY, ST_FIND, ST_STOPPING} rcp_state_t;
	typedef enum logic [1:0] {UNIT_TIME, UNIT_FEET, UNIT_BLOCKS} rcp_unit_t;
	typedef enum logic [2:0] {OP_NONE, OP_BIT, OP_ERASE, OP_RECORD, OP_PLAY, OP_FIND, OP_STOP,
		OP_CRIT} rcp_opk_t;
	typedef struct packed {
		logic [9:0] day;
		logic day_given;
		logic [15:0] hour;
		logic [15:0] min;
		logic [15:0] sec;
		logic [15:0] ms;
	} rcp_time_t;
	typedef struct packed {
		rcp_opk_t kind;
		logic [31:0] value;
		rcp_time_t tm;
		rcp_unit_t unit;
		logic int_clk;
		logic [31:0] mask;
	} rcp_op_t;
	typedef struct packed {
		logic body;
		logic [7:0] letter;
		logic [6:0] val;
	} rcp_resp_t;
	// Command word, right aligned in the line buffer
	function automatic rcp_cmd_t decode(input logic [8*WORD_CHARS-1:0] w);
		case (w)
			"BIT": decode = CMD_BIT;
			"CRITICAL": decode = CMD_CRITICAL;
			"DECLASSIFY": decode = CMD_DECLASSIFY;
			"DUB": decode = CMD_DUB;
			"ERASE": decode = CMD_ERASE;
			"EVENT": decode = CMD_EVENT;
			"FIND": decode = CMD_FIND;
			"PLAY": decode = CMD_PLAY;
			"RECORD": decode = CMD_RECORD;
			"REPLAY": decode = CMD_REPLAY;
			"RESET": decode = CMD_RESET;
			"SETUP": decode = CMD_SETUP;
			"SHUTTLE": decode = CMD_SHUTTLE;
			"STATUS": decode = CMD_STATUS;
			"STOP": decode = CMD_STOP;
			default: decode = CMD_UNKNOWN;
		endcase
	endfunction
	function automatic logic [6:0] state_code(input rcp_state_t s);
		case (s)
			ST_IDLE: state_code = 7'h01;
			ST_BIT: state_code = 7'h02;
			ST_ERASE: state_code = 7'h03;
			ST_RECORD: state_code = 7'h04;
			ST_PLAY: state_code = 7'h05;
			ST_FIND: state_code = 7'h06;
			ST_STARTING: state_code = 7'h07;
			ST_STOPPING: state_code = 7'h08;
			ST_FAIL: state_code = 7'h09;
			default: state_code = 7'h00;
		endcase
	endfunction
endpackage
`default_nettype wire

/* verilog/rcp_resp_tx.sv */
`timescale 1ns/1ps
`default_nettype none
module rcp_resp_tx (
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire rcp_pkg::rcp_resp_t resp,
	input wire logic tx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data
);
	localparam logic [2:0] IX_LETTER = 3'h0;
	localparam logic [2:0] IX_DIGITS = 3'h2;
	localparam logic [2:0] IX_STAR = 3'h6;
	localparam logic [6:0] TEN = 7'h0A;
	logic [2:0] idx_q;
	logic [2:0] idx_d;
	rcp_pkg::rcp_resp_t r_q;
	rcp_pkg::rcp_resp_t rs_w;
	logic [7:0] byte_w;
	wire logic adv_w = tx_valid & tx_ready;
	// Sequence start: letter, digits only, or the bare asterisk
	assign rs_w = start ? resp : r_q;
	assign idx_d = start ? (resp.body ? ((resp.letter != 8'h00) ? IX_LETTER : IX_DIGITS) : IX_STAR)
		: (adv_w ? idx_q + 3'h1 : idx_q);
	wire logic [6:0] tens_w = rs_w.val / TEN;
	wire logic [6:0] ones_w = rs_w.val - 7'(tens_w * TEN);
	// Byte for the position about to be shown
	always_comb begin
		case (idx_d)
			3'h0: byte_w = rs_w.letter;
			3'h1: byte_w = rcp_pkg::CH_SP;
			3'h2: byte_w = rcp_pkg::CH_0 + 8'(tens_w);
			3'h3: byte_w = rcp_pkg::CH_0 + 8'(ones_w);
			3'h4: byte_w = rcp_pkg::CH_CR;
			3'h5: byte_w = rcp_pkg::CH_LF;
			default: byte_w = rcp_pkg::CH_STAR;
		endcase
	end
	// Asterisk always ends the reply and frees the link
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_valid <= 1'b0;
			idx_q <= IX_STAR;
			r_q <= '0;
			tx_data <= 8'h00;
		end else begin
			if (start) begin
				tx_valid <= 1'b1;
			end else if (adv_w && idx_q == IX_STAR) begin
				tx_valid <= 1'b0;
			end
			idx_q <= idx_d;
			r_q <= rs_w;
			tx_data <= byte_w;
		end
	end
	a_star_last: assert property (@(posedge mclk) disable iff (rst)
		tx_valid && tx_ready && tx_data == rcp_pkg::CH_STAR |=> !tx_valid)
		else $error("reply continued past asterisk");
	a_body_then_star: assert property (@(posedge mclk) disable iff (rst)
		tx_valid && tx_ready && tx_data != rcp_pkg::CH_STAR |=> tx_valid)
		else $error("reply ended without asterisk");
endmodule
`default_nettype wire

/* verilog/rcp_parser.sv */
// Overview of operation
// - Every complete command line gets exactly one reply.
// - Reply starts the cycle after the line feed is taken.
// - Long operations answer at once; host polls status for completion.
// - Only unsolicited output is one asterisk on leaving power-on.
// - Hardware reset or reset command returns to power-on and reboots.
// - Power-on drops input; built-in test runs before commands apply.
// - Passing built-in test enters idle.
// - Starting and stopping last a configurable number of wait cycles.
// - Record uses external clock; playback clock external or internal.
// - Shuttle: at end point find start, then play again, repeating.
// - Record at end of recorded data; only erase rewinds it.
// - Playback runs forward only.
// - Command starts with a period, ends at carriage return line feed.
// - Words and parameters split by spaces; event text is free.
// - Extra terminators and spaces are ignored silently, except a space right after the period, which gives an unknown command.
// - Reply is optional body then asterisk marking readiness.
// - Parameters decimal, except critical mask read as hexadecimal.
// - Omitted unit for find, replay, shuttle reuses the last one.
// - Time parses day-hour:min:sec.ms, missing parts zero, day optional.
// - Setup shows or selects one of sixteen formats from zero.
// - Dub and replay act like play and shuttle with internal clock.
// - Failed command replies E and two-digit code; zero is unknown.
`timescale 1ns/1ps
`default_nettype none
module rcp_parser #(
	parameter int WAIT_CYC = 0,
	parameter int PWR_CYC = (rcp_pkg::PWR_UP_NS + rcp_pkg::CLK_NS - 1) / rcp_pkg::CLK_NS
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	output logic op_start,
	output rcp_pkg::rcp_op_t op,
	input wire logic op_done,
	input wire logic op_pass,
	input wire logic end_reached,
	input wire logic blk_written,
	output rcp_pkg::rcp_state_t rec_state,
	output logic [31:0] end_of_recorded_data,
	output logic [3:0] setup_fmt
);
	typedef enum logic [2:0] {PS_WAIT, PS_WORD, PS_GAP, PS_PARAM, PS_CR} rcp_ps_t;
	localparam int WB = 8 * rcp_pkg::WORD_CHARS;
	rcp_ps_t pst_q, pst_d;
	rcp_pkg::rcp_state_t st_q, st_d, tgt_q, tgt_d;
	rcp_pkg::rcp_cmd_t cmd_q;
	rcp_pkg::rcp_unit_t unit_q, unit_d, unit_w;
	rcp_pkg::rcp_op_t base_w, opn_w, find_q, find_d, play_q, play_d;
	rcp_pkg::rcp_resp_t resp_w;
	logic [WB-1:0] word_q;
	logic [1:0] ntok_q, tfi_q;
	logic [31:0] acc_q, hex_q, pwr_q, rp_q;
	logic [15:0] tf_q [4];
	logic [9:0] day_q;
	logic day_given_q, bad_q, bad2_q, shut_q, shut_d, rx_ready_q, go_w, send_w, evt_w, unit_ok_w;
	logic [7:0] ltr_q;
	logic [3:0] fmt_q, fmt_d;
	logic [15:0] wait_q;
	// Character classes
	wire logic acc_w = rx_valid & rx_ready_q & (st_q != rcp_pkg::ST_POWER_ON);
	wire logic is_sp_w = rx_data == rcp_pkg::CH_SP;
	wire logic is_cr_w = rx_data == rcp_pkg::CH_CR;
	wire logic is_lf_w = rx_data == rcp_pkg::CH_LF;
	wire logic is_dot_w = rx_data == rcp_pkg::CH_DOT;
	wire logic is_dig_w = rx_data >= rcp_pkg::CH_0 && rx_data <= rcp_pkg::CH_9;
	wire logic is_hex_w = is_dig_w | (rx_data >= rcp_pkg::CH_A && rx_data <= rcp_pkg::CH_F);
	wire logic [3:0] nib_w = is_dig_w ? 4'(rx_data - rcp_pkg::CH_0) : 4'(rx_data - rcp_pkg::CH_A + 8'h0A);
	wire logic [31:0] dec_w = 32'({acc_q, 3'h0} + {acc_q, 1'h0} + 35'(nib_w));
	// Token boundaries; runs of spaces collapse in the gap state
	wire logic word_ch_w = acc_w & (pst_q == PS_WORD) & !is_sp_w & !is_cr_w;
	wire logic word_end_w = acc_w & (pst_q == PS_WORD) & (is_sp_w | is_cr_w);
	wire logic in_tok_w = (pst_q == PS_GAP || pst_q == PS_PARAM) && !is_sp_w && !is_cr_w;
	wire logic pchar_w = acc_w & in_tok_w;
	wire logic tok_start_w = pchar_w & (pst_q == PS_GAP);
	wire logic [1:0] pidx_w = (pst_q == PS_GAP && ntok_q != 2'h3) ? ntok_q + 2'h1 : ntok_q;
	wire logic p1_w = pchar_w & (pidx_w == 2'h1);
	wire logic p2_w = pchar_w & (pidx_w == 2'h2);
	wire logic tok_end_w = acc_w & (pst_q == PS_PARAM) & (is_sp_w | is_cr_w);
	wire logic line_go_w = acc_w & (pst_q == PS_WAIT) & is_dot_w;
	wire logic line_done_w = acc_w & (pst_q == PS_CR) & is_lf_w;
	wire logic idle_w = st_q == rcp_pkg::ST_IDLE;
	// Unit letter, or the last one given when absent
	assign unit_ok_w = ntok_q < 2'h2 || ltr_q == rcp_pkg::CH_T || ltr_q == rcp_pkg::CH_F
		|| ltr_q == rcp_pkg::CH_B;
	assign unit_w = (ntok_q < 2'h2) ? unit_q : (ltr_q == rcp_pkg::CH_F) ? rcp_pkg::UNIT_FEET
		: (ltr_q == rcp_pkg::CH_B) ? rcp_pkg::UNIT_BLOCKS : rcp_pkg::UNIT_TIME;
	// Operation fields from the parsed parameters
	always_comb begin
		base_w = '0;
		base_w.kind = rcp_pkg::OP_NONE;
		base_w.value = acc_q;
		base_w.tm.day = day_q;
		base_w.tm.day_given = day_given_q;
		base_w.tm.hour = tf_q[0];
		base_w.tm.min = tf_q[1];
		base_w.tm.sec = tf_q[2];
		base_w.tm.ms = tf_q[3];
		base_w.unit = unit_w;
		base_w.int_clk = 1'b0;
		base_w.mask = hex_q;
	end
	// Line framing; stray CR or LF between lines falls in the wait state
	always_comb begin
		pst_d = pst_q;
		if (st_q == rcp_pkg::ST_POWER_ON) begin
			pst_d = PS_WAIT;
		end else if (acc_w) begin
			case (pst_q)
				PS_WAIT: if (is_dot_w) pst_d = PS_WORD;
				PS_WORD, PS_PARAM: if (is_cr_w) pst_d = PS_CR; else if (is_sp_w) pst_d = PS_GAP;
				PS_GAP: if (is_cr_w) pst_d = PS_CR; else if (!is_sp_w) pst_d = PS_PARAM;
				PS_CR: pst_d = is_cr_w ? PS_CR : PS_WAIT;
				default: pst_d = PS_WAIT;
			endcase
		end
	end
	// Line buffer and parameter collection
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			word_q <= '0;
			cmd_q <= rcp_pkg::CMD_UNKNOWN;
			ntok_q <= 2'h0;
			tfi_q <= 2'h0;
			acc_q <= 32'h0;
			hex_q <= 32'h0;
			tf_q <= '{default: 16'h0};
			day_q <= 10'h0;
			day_given_q <= 1'b0;
			bad_q <= 1'b0;
			bad2_q <= 1'b0;
			ltr_q <= 8'h00;
		end else if (line_go_w) begin
			word_q <= '0;
			ntok_q <= 2'h0;
			tfi_q <= 2'h0;
			acc_q <= 32'h0;
			hex_q <= 32'h0;
			tf_q <= '{default: 16'h0};
			day_given_q <= 1'b0;
			bad_q <= 1'b0;
			bad2_q <= 1'b0;
		end else begin
			if (word_ch_w) word_q <= {word_q[WB-9:0], rx_data};
			if (word_end_w) cmd_q <= rcp_pkg::decode(word_q);
			if (tok_start_w) ntok_q <= pidx_w;
			if (p1_w) begin
				if (is_dig_w) begin
					acc_q <= dec_w;
				end else if (rx_data == rcp_pkg::CH_DASH) begin
					day_q <= acc_q[9:0];
					day_given_q <= 1'b1;
					acc_q <= 32'h0;
				end else if (rx_data == rcp_pkg::CH_COLON || is_dot_w) begin
					tf_q[tfi_q] <= acc_q[15:0];
					tfi_q <= is_dot_w ? 2'h3 : tfi_q + 2'h1;
					acc_q <= 32'h0;
				end else begin
					bad_q <= 1'b1;
				end
			end
			if (tok_end_w && ntok_q == 2'h1) tf_q[tfi_q] <= acc_q[15:0];
			if (p2_w) begin
				hex_q <= {hex_q[27:0], nib_w};
				if (!is_hex_w) bad2_q <= 1'b1;
				if (tok_start_w) ltr_q <= rx_data;
			end
		end
	end
	function automatic rcp_pkg::rcp_resp_t body(input logic [7:0] l, input logic [6:0] v);
		body = '{body: 1'b1, letter: l, val: v};
	endfunction
	// Recorder states: engine events first, then the command just framed
	always_comb begin
		st_d = st_q;
		tgt_d = tgt_q;
		send_w = 1'b0;
		resp_w = '0;
		go_w = 1'b0;
		opn_w = base_w;
		shut_d = shut_q;
		fmt_d = fmt_q;
		unit_d = unit_q;
		find_d = find_q;
		play_d = play_q;
		case (st_q)
			rcp_pkg::ST_POWER_ON: if (pwr_q == 32'h0 && !tx_valid) begin
				st_d = rcp_pkg::ST_BIT;
				send_w = 1'b1;
				go_w = 1'b1;
				opn_w.kind = rcp_pkg::OP_BIT;
			end
			rcp_pkg::ST_BIT: if (op_done) st_d = op_pass ? rcp_pkg::ST_IDLE : rcp_pkg::ST_FAIL;
			rcp_pkg::ST_ERASE: if (op_done) st_d = rcp_pkg::ST_IDLE;
			rcp_pkg::ST_STARTING: if (wait_q == 16'h0) st_d = tgt_q;
			rcp_pkg::ST_STOPPING: if (wait_q == 16'h0) st_d = rcp_pkg::ST_IDLE;
			rcp_pkg::ST_PLAY: if (end_reached) begin
				st_d = shut_q ? rcp_pkg::ST_FIND : rcp_pkg::ST_STOPPING;
				go_w = shut_q;
				opn_w = find_q;
				opn_w.kind = rcp_pkg::OP_FIND; // Shuttle without a prior find still seeks
			end
			rcp_pkg::ST_FIND: if (op_done) begin
				st_d = shut_q ? rcp_pkg::ST_PLAY : rcp_pkg::ST_IDLE;
				go_w = shut_q;
				opn_w = play_q;
			end
			default: st_d = st_q;
		endcase
		evt_w = st_d != st_q;
		if (line_done_w) begin
			send_w = 1'b1;
			case (cmd_q)
				rcp_pkg::CMD_BIT: if ((idle_w || st_q == rcp_pkg::ST_FAIL) && !evt_w) begin
					st_d = rcp_pkg::ST_BIT;
					go_w = 1'b1;
					opn_w.kind = rcp_pkg::OP_BIT;
				end else resp_w = body(rcp_pkg::CH_E, rcp_pkg::ERR_MODE);
				rcp_pkg::CMD_ERASE, rcp_pkg::CMD_DECLASSIFY: if (idle_w && !evt_w) begin
					st_d = rcp_pkg::ST_ERASE;
					go_w = 1'b1;
					opn_w.kind = rcp_pkg::OP_ERASE;
				end else resp_w = body(rcp_pkg::CH_E, rcp_pkg::ERR_MODE);
				rcp_pkg::CMD_RESET: begin
					st_d = rcp_pkg::ST_POWER_ON;
					shut_d = 1'b0;
				end
				rcp_pkg::CMD_RECORD: if (idle_w && !evt_w) begin
					st_d = rcp_pkg::ST_STARTING;
					tgt_d = rcp_pkg::ST_RECORD;
					go_w = 1'b1;
					opn_w.kind = rcp_pkg::OP_RECORD;
					opn_w.value = rp_q;
				end else resp_w = body(rcp_pkg::CH_E, rcp_pkg::ERR_MODE);
				rcp_pkg::CMD_PLAY, rcp_pkg::CMD_DUB: if (idle_w && !evt_w) begin
					st_d = rcp_pkg::ST_STARTING;
					tgt_d = rcp_pkg::ST_PLAY;
					go_w = 1'b1;
					shut_d = 1'b0;
					opn_w.kind = rcp_pkg::OP_PLAY;
					opn_w.int_clk = cmd_q == rcp_pkg::CMD_DUB;
				end else resp_w = body(rcp_pkg::CH_E, rcp_pkg::ERR_MODE);
				rcp_pkg::CMD_SHUTTLE, rcp_pkg::CMD_REPLAY: if (!unit_ok_w || bad_q) begin
					resp_w = body(rcp_pkg::CH_E, rcp_pkg::ERR_PARAM);
				end else if ((idle_w || st_q == rcp_pkg::ST_PLAY) && !evt_w) begin
					shut_d = 1'b1;
					unit_d = unit_w;
					play_d = base_w;
					play_d.kind = rcp_pkg::OP_PLAY;
					play_d.int_clk = cmd_q == rcp_pkg::CMD_REPLAY;
					opn_w = play_d;
					go_w = idle_w;
					if (idle_w) st_d = rcp_pkg::ST_STARTING;
					tgt_d = rcp_pkg::ST_PLAY;
				end else resp_w = body(rcp_pkg::CH_E, rcp_pkg::ERR_MODE);
				rcp_pkg::CMD_FIND: if (ntok_q == 2'h0) begin
					resp_w = '0;
				end else if (!unit_ok_w || bad_q) begin
					resp_w = body(rcp_pkg::CH_E, rcp_pkg::ERR_PARAM);
				end else if (idle_w && !evt_w) begin
					st_d = rcp_pkg::ST_FIND;
					unit_d = unit_w;
					shut_d = 1'b0;
					go_w = 1'b1;
					opn_w.kind = rcp_pkg::OP_FIND;
					find_d = opn_w;
				end else resp_w = body(rcp_pkg::CH_E, rcp_pkg::ERR_MODE);
				rcp_pkg::CMD_STOP: if ((st_q == rcp_pkg::ST_RECORD || st_q == rcp_pkg::ST_PLAY
					|| st_q == rcp_pkg::ST_STARTING) && !evt_w) begin
					st_d = rcp_pkg::ST_STOPPING;
					shut_d = 1'b0;
					go_w = 1'b1;
					opn_w.kind = rcp_pkg::OP_STOP;
				end else resp_w = body(rcp_pkg::CH_E, rcp_pkg::ERR_MODE);
				rcp_pkg::CMD_STATUS: resp_w = body(rcp_pkg::CH_S, rcp_pkg::state_code(st_q));
				rcp_pkg::CMD_SETUP: if (ntok_q == 2'h0) begin
					resp_w = body(8'h00, 7'(fmt_q));
				end else if (!bad_q && acc_q < 32'(rcp_pkg::SETUP_FORMATS)) begin
					fmt_d = acc_q[3:0];
				end else resp_w = body(rcp_pkg::CH_E, rcp_pkg::ERR_PARAM);
				rcp_pkg::CMD_CRITICAL: if (ntok_q >= 2'h2) begin
					if (bad_q || bad2_q) begin
						resp_w = body(rcp_pkg::CH_E, rcp_pkg::ERR_PARAM);
					end else begin
						go_w = !evt_w;
						opn_w.kind = rcp_pkg::OP_CRIT;
					end
				end
				rcp_pkg::CMD_EVENT: resp_w = '0;
				default: resp_w = body(rcp_pkg::CH_E, rcp_pkg::ERR_CMD);
			endcase
		end
	end
	// State, counters and issued operation
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pst_q <= PS_WAIT;
			st_q <= rcp_pkg::ST_POWER_ON;
			tgt_q <= rcp_pkg::ST_IDLE;
			pwr_q <= 32'(PWR_CYC);
			wait_q <= 16'h0;
			shut_q <= 1'b0;
			fmt_q <= 4'h0;
			unit_q <= rcp_pkg::UNIT_TIME;
			find_q <= '0;
			play_q <= '0;
			op <= '0;
			op_start <= 1'b0;
			rx_ready_q <= 1'b1;
		end else begin
			pst_q <= pst_d;
			st_q <= st_d;
			tgt_q <= tgt_d;
			if (st_d == rcp_pkg::ST_POWER_ON && st_q != rcp_pkg::ST_POWER_ON) pwr_q <= 32'(PWR_CYC);
			else if (pwr_q != 32'h0) pwr_q <= pwr_q - 32'h1;
			if (st_d != st_q) wait_q <= 16'(WAIT_CYC);
			else if (wait_q != 16'h0) wait_q <= wait_q - 16'h1;
			shut_q <= shut_d;
			fmt_q <= fmt_d;
			unit_q <= unit_d;
			find_q <= find_d;
			play_q <= play_d;
			op_start <= go_w;
			if (go_w) op <= opn_w;
			rx_ready_q <= !line_done_w && !send_w && !tx_valid;
		end
	end
	// Record point only moves forward; erase rewinds it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) rp_q <= 32'h0;
		else if (st_q == rcp_pkg::ST_ERASE && op_done) rp_q <= 32'h0;
		else if (blk_written) rp_q <= rp_q + 32'h1;
	end
	rcp_resp_tx u_tx (
		.mclk(mclk),
		.rst(rst),
		.start(send_w),
		.resp(resp_w),
		.tx_ready(tx_ready),
		.tx_valid(tx_valid),
		.tx_data(tx_data)
	);
	assign rx_ready = rx_ready_q;
	assign rec_state = st_q;
	assign end_of_recorded_data = rp_q;
	assign setup_fmt = fmt_q;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	sequence s_err_head;
		tx_valid && tx_data == rcp_pkg::CH_E;
	endsequence
	a_reply_next: assert property (line_done_w |=> tx_valid && !rx_ready)
		else $error("reply did not start after line feed");
	a_no_unasked: assert property ($rose(tx_valid) |-> $past(send_w))
		else $error("unsolicited output");
	a_boot_star: assert property (st_q == rcp_pkg::ST_POWER_ON && st_d == rcp_pkg::ST_BIT
		|=> tx_valid && tx_data == rcp_pkg::CH_STAR)
		else $error("boot message is not a single asterisk");
	a_power_drop: assert property (st_q == rcp_pkg::ST_POWER_ON && st_d == rcp_pkg::ST_POWER_ON
		|=> pst_q == PS_WAIT && !op_start)
		else $error("command taken in power-on");
	a_bit_idle: assert property (st_q == rcp_pkg::ST_BIT && op_done && op_pass && !line_done_w
		|=> st_q == rcp_pkg::ST_IDLE)
		else $error("passing test did not reach idle");
	a_reset_cmd: assert property (line_done_w && cmd_q == rcp_pkg::CMD_RESET
		|=> st_q == rcp_pkg::ST_POWER_ON)
		else $error("reset command ignored");
	a_erase_rewind: assert property (st_q == rcp_pkg::ST_ERASE && op_done
		|=> end_of_recorded_data == 32'h0)
		else $error("erase left record point");
	a_shuttle_find: assert property (st_q == rcp_pkg::ST_PLAY && shut_q && end_reached && !line_done_w
		|=> st_q == rcp_pkg::ST_FIND && op_start && op.kind == rcp_pkg::OP_FIND)
		else $error("shuttle did not refind start");
	a_dub_clock: assert property (line_done_w && cmd_q == rcp_pkg::CMD_DUB && idle_w && !evt_w
		|=> op_start && op.int_clk ##[1:8] st_q == rcp_pkg::ST_PLAY || line_done_w)
		else $error("dub did not select internal clock");
	a_unknown_err: assert property (line_done_w && cmd_q == rcp_pkg::CMD_UNKNOWN
		|=> s_err_head)
		else $error("unknown command without error reply");
endmodule
`default_nettype wire

/* tb/rcp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rcp_host (
	input wire logic mclk,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic tx_ready
);
	string rcv = "";
	logic slow = 1'b0;
	logic stuck = 1'b0;
	logic [1:0] cnt = 2'h0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	// Reply bytes; slow mode stalls three cycles in four
	always @(negedge mclk) begin
		cnt <= cnt + 2'h1;
		tx_ready = !slow || cnt == 2'h3;
		if (tx_valid && tx_ready) begin
			rcv = {rcv, $sformatf("%c", tx_data)};
		end
	end
	// One byte per handshake, held until taken
	task automatic send(input string s);
		int i;
		int n;
		for (i = 0; i < s.len(); i++) begin
			@(negedge mclk);
			rx_valid = 1'b1;
			rx_data = s[i];
			for (n = 0; !rx_ready && n < 2000; n++) @(negedge mclk);
			if (n == 2000) stuck = 1'b1;
			@(posedge mclk);
		end
		@(negedge mclk);
		rx_valid = 1'b0;
		rx_data = ~rx_data; // Released line must not keep the last byte
	endtask
endmodule
`default_nettype wire

/* tb/test_rcp_parser.sv */
`timescale 1ns/1ps
`default_nettype none
module test_rcp_parser;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic rx_valid, rx_ready, tx_valid, tx_ready, op_start;
	logic [7:0] rx_data, tx_data;
	logic [3:0] ev_q = 4'h0; // Done, pass, end point, block
	rcp_pkg::rcp_op_t op;
	rcp_pkg::rcp_state_t rec_state;
	logic [31:0] end_of_recorded_data;
	logic [3:0] setup_fmt;
	int mismatches = 0;
	int check_count = 0;
	int lat;
	int n_op = 0;
	// Operation starts, counted where op_start has settled
	always @(negedge mclk) if (op_start) n_op++;
	// Clock
	initial begin
		forever #5 mclk = ~mclk;
	end
	// Short power-on keeps reboots cheap
	rcp_parser #(.WAIT_CYC(2), .PWR_CYC(4)) dut (.mclk(mclk), .rst(rst), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .op_start(op_start), .op(op), .op_done(ev_q[3]), .op_pass(ev_q[2]),
		.end_reached(ev_q[1]), .blk_written(ev_q[0]), .rec_state(rec_state),
		.end_of_recorded_data(end_of_recorded_data), .setup_fmt(setup_fmt));
	rcp_host host (.mclk(mclk), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
		.rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready));
	// Comparisons
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chks(input string got, input string exp);
		check_count++;
		if (got != exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Engine event pulse, then settle
	task automatic ev(input logic [3:0] m);
		@(negedge mclk);
		ev_q = m;
		@(negedge mclk);
		ev_q = 4'h0;
		repeat (20) @(negedge mclk);
	endtask
	// Line out, reply in; the quiet tail catches any second reply
	task automatic cmd(input string s, input string exp);
		int n;
		host.rcv = "";
		host.send(s);
		for (n = 0; host.rcv.len() == 0 && n < 300; n++) @(negedge mclk);
		lat = n;
		for (n = 0; host.rcv[host.rcv.len() - 1] != rcp_pkg::CH_STAR && n < 500; n++) @(negedge mclk);
		if (n == 500 || host.stuck) begin
			mismatches++;
			end_of_test();
		end
		repeat (20) @(negedge mclk);
		chks(host.rcv, exp);
	endtask
	task automatic t_boot();
		cmd(".", "*");
		chk(rec_state, rcp_pkg::ST_BIT);
		chk(op.kind, rcp_pkg::OP_BIT);
		ev(4'hC);
		chk(n_op, 32'h1);
		chk(rec_state, rcp_pkg::ST_IDLE);
		$display("boot done");
	endtask
	task automatic t_status();
		cmd("\r\n.STATUS  \r\n", "S 01\r\n*");
		chk(lat <= 2, 1);
		host.rcv = "";
		host.send("\r\n \r\n");
		repeat (20) @(negedge mclk);
		chks(host.rcv, "");
		$display("status done");
	endtask
	task automatic t_setup();
		host.slow = 1'b1;
		cmd(".TMATS\r\n", "E 00\r\n*");
		cmd(".SETUP 16\r\n", "E 01\r\n*");
		cmd(".SETUP  15\r\n", "*");
		chk(setup_fmt, 4'hF);
		cmd(".SETUP\r\n", "15\r\n*");
		host.slow = 1'b0;
		$display("setup done");
	endtask
	task automatic t_record();
		cmd(".RECORD\r\n", "*");
		chk(op.kind, rcp_pkg::OP_RECORD);
		chk(op.value, 32'h0);
		chk(op.int_clk, 1'b0);
		chk(rec_state, rcp_pkg::ST_RECORD);
		ev(4'h1);
		ev(4'h1);
		chk(end_of_recorded_data, 32'h2);
		cmd(".STOP\r\n", "*");
		chk(rec_state, rcp_pkg::ST_IDLE);
		cmd(".RECORD\r\n", "*");
		chk(op.value, 32'h2);
		cmd(".STOP\r\n", "*");
		cmd(".ERASE\r\n", "*");
		chk(rec_state, rcp_pkg::ST_ERASE);
		ev(4'h8);
		chk(end_of_recorded_data, 32'h0);
		$display("record done");
	endtask
	task automatic t_shuttle();
		cmd(".FIND 12 B\r\n", "*");
		chk(op.value, 32'hC);
		ev(4'h8);
		cmd(".SHUTTLE 9\r\n", "*");
		chk(op.unit, rcp_pkg::UNIT_BLOCKS);
		chk(rec_state, rcp_pkg::ST_PLAY);
		ev(4'h2);
		chk(op.kind, rcp_pkg::OP_FIND);
		chk(op.value, 32'hC);
		ev(4'h8);
		chk(op.kind, rcp_pkg::OP_PLAY);
		chk(op.int_clk, 1'b0);
		cmd(".STOP\r\n", "*");
		cmd(".REPLAY 9\r\n", "*");
		chk(op.int_clk, 1'b1);
		cmd(".STOP\r\n", "*");
		$display("shuttle done");
	endtask
	// Wrong-state error, full time field, dub, event text, failing test, secure erase
	task automatic t_modes();
		cmd(".STOP\r\n", "E 02\r\n*");
		cmd(".FIND 123-17:30:05.232 T\r\n", "*");
		chk(op.tm.day, 32'h7B);
		chk(op.tm.day_given, 32'h1);
		chk(op.tm.hour, 32'h11);
		chk(op.tm.min, 32'h1E);
		chk(op.tm.sec, 32'h5);
		chk(op.tm.ms, 32'hE8);
		chk(op.unit, rcp_pkg::UNIT_TIME);
		ev(4'h8);
		cmd(".DUB\r\n", "*");
		chk(op.int_clk, 1'b1);
		chk(rec_state, rcp_pkg::ST_PLAY);
		cmd(".STOP\r\n", "*");
		cmd(".EVENT some free text\r\n", "*");
		cmd(".BIT\r\n", "*");
		ev(4'h8);
		cmd(".STATUS\r\n", "S 09\r\n*");
		cmd(".BIT\r\n", "*");
		ev(4'hC);
		cmd(".DECLASSIFY\r\n", "*");
		chk(rec_state, rcp_pkg::ST_ERASE);
		ev(4'h8);
		chk(rec_state, rcp_pkg::ST_IDLE);
		$display("modes done");
	endtask
	task automatic t_reset();
		cmd(".CRITICAL 1 1F0\r\n", "*");
		chk(op.mask, 32'h1F0);
		cmd(".RESET\r\n", "**");
		chk(rec_state, rcp_pkg::ST_BIT);
		rst = 1'b1;
		@(negedge mclk);
		chk(rec_state, rcp_pkg::ST_POWER_ON);
		chk(setup_fmt, 4'h0);
		$display("reset done");
	endtask
	// Main sequence
	initial begin
		repeat (12) @(negedge mclk);
		rst = 1'b0;
		t_boot();
		t_status();
		t_setup();
		t_record();
		t_shuttle();
		t_modes();
		t_reset();
		end_of_test();
	end
endmodule
`default_nettype wire
